// >>> rtl/tpe_map.vh
`ifndef TPE_MAP_VH
`define TPE_MAP_VH

// Pixel, half-pixel, character and tally widths
`define TPE_PIX_W 24
`define TPE_HALF_W 12
`define TPE_CHAR_W 10
`define TPE_DISP_W 5

// Buffer word layout
`define TPE_W_DE 28
`define TPE_W_VS 27
`define TPE_W_HS 26
`define TPE_W_C2 25
`define TPE_W_C1 24
`define TPE_WORD_W 29

// Fixed control characters, index {c1,c0}
`define TPE_CTRL_00 10'h354
`define TPE_CTRL_01 10'h0AB
`define TPE_CTRL_10 10'h154
`define TPE_CTRL_11 10'h2AB

// Reserved control bits are always sent as zero
`define TPE_CTL3_VALUE 1'b0
`define TPE_CTL0_VALUE 1'b0

// Reset values of configuration
`define TPE_RST_BUS_WIDTH 1'b1
`define TPE_RST_EDGE 1'b1
`define TPE_RST_CLK_STYLE 1'b0

// Strap capture: edges after reset release before straps are settled
`define TPE_STRAP_AGE 2'h2

// Pixel period limits in ps and system clock period in ps
`define TPE_PIXEL_MIN_PS 6060
`define TPE_PIXEL_MAX_PS 40000
`define TPE_CLK_PERIOD_PS 10000

`endif

// >>> rtl/tpe_buf.v
`timescale 1ns/1ps
`default_nettype none
module tpe_buf #(
  parameter W = 29,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire clk,
  input wire rst_b,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/tpe_encoder.v
// Contract
// - Send exactly one of two candidate characters
// - Running disparity tally picks the balanced character
// - Data enable high sends red, green, blue
// - Data enable low sends syncs and controls
// - Bits 23:16, 15:8, 7:0 to channels 2,1,0
// - Blanking: ctl2 ch2, ctl1 ch1, syncs ch0
// - Third control bit always encoded zero
// - Send user controls during vertical blanking
// - Pixel period equals link period, 6.06-40 ns
// - Accept 12-line or 24-line pixel input
// - Straps set defaults, host may override later
// - Display detect via sense, or hot-plug with i2c_enable high
// - 24-line, edge 0: sample on falling edge
// - 24-line, edge 1: sample on rising edge
// - 12-line mode: sample on both edges
// - Bus width select 0 is 12, 1 is 24
// - Two 12-bit halves form one pixel
`timescale 1ns/1ps
`default_nettype none
`include "tpe_map.vh"
module tpe_encoder #(
  parameter BUF_DEPTH = 2,
  parameter BUF_AW = 1
) (
  input wire clk,
  input wire rst_b,
  input wire input_pixel_clock,
  input wire [`TPE_PIX_W-1:0] pixel_data,
  input wire data_enable,
  input wire hsync,
  input wire vsync,
  input wire ctl1,
  input wire ctl2,
  input wire strap_bus_width_select,
  input wire strap_edge_select,
  input wire strap_clock_style_select,
  input wire host_cfg_load,
  input wire host_bus_width_select,
  input wire host_edge_select,
  input wire host_clock_style_select,
  input wire receiver_sense,
  input wire hot_plug,
  input wire i2c_enable,
  input wire char_ready,
  output reg pixel_ready,
  output reg pixel_dropped,
  output reg char_valid,
  output wire [`TPE_CHAR_W-1:0] red_serial_channel,
  output wire [`TPE_CHAR_W-1:0] green_serial_channel,
  output wire [`TPE_CHAR_W-1:0] blue_serial_channel,
  output reg link_clock_output,
  output reg display_present,
  output reg bus_width_select,
  output reg edge_select,
  output reg clock_style_select
);
  localparam IN_W = `TPE_WORD_W;

  // TMDS character choice; returns {new tally, character}
  function [`TPE_DISP_W+`TPE_CHAR_W-1:0] tpe_tmds;
    input [7:0] d;
    input [`TPE_DISP_W-1:0] cnt_in;
    integer i;
    integer n1;
    integer n1m;
    integer diff;
    integer cnt;
    reg xn;
    reg [8:0] qm;
    reg [9:0] q;
    begin
      n1 = 0;
      for (i = 0; i < 8; i = i + 1) begin
        n1 = n1 + d[i];
      end
      xn = (n1 > 4) || (n1 == 4 && !d[0]);
      qm[0] = d[0];
      for (i = 1; i < 8; i = i + 1) begin
        qm[i] = xn ? ~(qm[i-1] ^ d[i]) : (qm[i-1] ^ d[i]);
      end
      qm[8] = ~xn;
      n1m = 0;
      for (i = 0; i < 8; i = i + 1) begin
        n1m = n1m + qm[i];
      end
      diff = 2 * n1m - 8;
      cnt = cnt_in;
      if (cnt_in[`TPE_DISP_W-1]) begin
        cnt = cnt - (1 << `TPE_DISP_W);
      end
      // Pick the inverted or plain form against the tally
      if (cnt == 0 || diff == 0) begin
        q = {~qm[8], qm[8], qm[8] ? qm[7:0] : ~qm[7:0]};
        cnt = qm[8] ? cnt + diff : cnt - diff;
      end else if ((cnt > 0 && diff > 0) || (cnt < 0 && diff < 0)) begin
        q = {1'b1, qm[8], ~qm[7:0]};
        cnt = cnt + 2 * qm[8] - diff;
      end else begin
        q = {1'b0, qm[8], qm[7:0]};
        cnt = cnt - 2 * (1 - qm[8]) + diff;
      end
      tpe_tmds = {cnt[`TPE_DISP_W-1:0], q};
    end
  endfunction

  function [`TPE_CHAR_W-1:0] tpe_ctrl;
    input [1:0] c;
    begin
      case (c)
        2'h0: tpe_ctrl = `TPE_CTRL_00;
        2'h1: tpe_ctrl = `TPE_CTRL_01;
        2'h2: tpe_ctrl = `TPE_CTRL_10;
        default: tpe_ctrl = `TPE_CTRL_11;
      endcase
    end
  endfunction

  // Pin synchronisers; third stage holds the value just before an edge
  wire [IN_W:0] pins;
  reg [IN_W:0] pin_s1;
  reg [IN_W:0] pin_s2;
  reg [IN_W:0] pin_s3;
  reg [5:0] misc_s1;
  reg [5:0] misc_s2;
  wire clk_now;
  wire clk_old;
  wire rise;
  wire fall;
  wire [IN_W-1:0] word_old;

  assign pins = {input_pixel_clock, data_enable, vsync, hsync, ctl2, ctl1, pixel_data};
  assign clk_now = pin_s2[IN_W];
  assign clk_old = pin_s3[IN_W];
  assign rise = clk_now & ~clk_old;
  assign fall = ~clk_now & clk_old;
  assign word_old = pin_s3[IN_W-1:0];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= {(IN_W+1){1'b0}};
      pin_s2 <= {(IN_W+1){1'b0}};
      pin_s3 <= {(IN_W+1){1'b0}};
      misc_s1 <= 6'h00;
      misc_s2 <= 6'h00;
    end else begin
      pin_s1 <= pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      misc_s1 <= {strap_bus_width_select, strap_edge_select, strap_clock_style_select,
                  receiver_sense, hot_plug, i2c_enable};
      misc_s2 <= misc_s1;
    end
  end

  // Configuration: straps after release, host load afterwards
  reg [1:0] strap_age;
  reg strap_taken;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_age <= 2'h0;
      strap_taken <= 1'b0;
      bus_width_select <= `TPE_RST_BUS_WIDTH;
      edge_select <= `TPE_RST_EDGE;
      clock_style_select <= `TPE_RST_CLK_STYLE;
    end else if (!strap_taken) begin
      strap_age <= strap_age + 1'b1;
      if (strap_age == `TPE_STRAP_AGE) begin
        strap_taken <= 1'b1;
        bus_width_select <= misc_s2[5];
        edge_select <= misc_s2[4];
        clock_style_select <= misc_s2[3];
      end
    end else if (host_cfg_load) begin
      bus_width_select <= host_bus_width_select;
      edge_select <= host_edge_select;
      clock_style_select <= host_clock_style_select;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      display_present <= 1'b0;
      link_clock_output <= 1'b0;
    end else begin
      display_present <= misc_s2[2] | (misc_s2[0] & misc_s2[1]);
      link_clock_output <= clk_now;
    end
  end

  // Capture: single edge in 24-line mode, two halves in 12-line mode
  wire prim_edge;
  wire sec_edge;
  reg [`TPE_HALF_W-1:0] low_half;
  reg have_low;
  reg push_valid;
  reg [IN_W-1:0] push_word;
  wire buf_in_ready;

  assign prim_edge = edge_select ? rise : fall;
  assign sec_edge = edge_select ? fall : rise;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_half <= {`TPE_HALF_W{1'b0}};
      have_low <= 1'b0;
      push_valid <= 1'b0;
      push_word <= {IN_W{1'b0}};
      pixel_dropped <= 1'b0;
      pixel_ready <= 1'b0;
    end else begin
      push_valid <= 1'b0;
      pixel_ready <= buf_in_ready;
      if (push_valid && !buf_in_ready) begin
        pixel_dropped <= 1'b1;
      end
      if (bus_width_select) begin
        have_low <= 1'b0;
        if (prim_edge) begin
          push_valid <= 1'b1;
          push_word <= word_old;
        end
      end else begin
        if (prim_edge) begin
          low_half <= word_old[`TPE_HALF_W-1:0];
          have_low <= 1'b1;
        end else if (sec_edge && have_low) begin
          have_low <= 1'b0;
          push_valid <= 1'b1;
          push_word <= {word_old[IN_W-1:`TPE_PIX_W],
                        word_old[`TPE_HALF_W-1:0], low_half};
        end
      end
    end
  end

  wire buf_valid;
  wire [IN_W-1:0] buf_word;
  wire pop;

  assign pop = buf_valid & (~char_valid | char_ready);

  tpe_buf #(
    .W(IN_W),
    .DEPTH(BUF_DEPTH),
    .AW(BUF_AW)
  ) u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(push_valid),
    .in_ready(buf_in_ready),
    .in_data(push_word),
    .out_valid(buf_valid),
    .out_ready(pop),
    .out_data(buf_word)
  );

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      char_valid <= 1'b0;
    end else if (pop) begin
      char_valid <= 1'b1;
    end else if (char_ready) begin
      char_valid <= 1'b0;
    end
  end

  // Control pairs per channel, {c1,c0}; syncs and controls used only in blanking
  wire [5:0] ctl_pairs;
  wire [3*`TPE_CHAR_W-1:0] chars;
  wire de_now;

  assign de_now = buf_word[`TPE_W_DE];
  assign ctl_pairs = {`TPE_CTL3_VALUE, buf_word[`TPE_W_C2],
                      buf_word[`TPE_W_C1], `TPE_CTL0_VALUE,
                      buf_word[`TPE_W_VS], buf_word[`TPE_W_HS]};

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_ch
      reg [`TPE_DISP_W-1:0] disp;
      reg [`TPE_CHAR_W-1:0] chr;
      wire [`TPE_DISP_W+`TPE_CHAR_W-1:0] enc;

      assign enc = tpe_tmds(buf_word[8*ch+7:8*ch], disp);
      assign chars[`TPE_CHAR_W*ch+`TPE_CHAR_W-1:`TPE_CHAR_W*ch] = chr;

      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          disp <= {`TPE_DISP_W{1'b0}};
          chr <= {`TPE_CHAR_W{1'b0}};
        end else if (pop) begin
          if (de_now) begin
            chr <= enc[`TPE_CHAR_W-1:0];
            disp <= enc[`TPE_DISP_W+`TPE_CHAR_W-1:`TPE_CHAR_W];
          end else begin
            chr <= tpe_ctrl(ctl_pairs[2*ch+1:2*ch]);
            disp <= {`TPE_DISP_W{1'b0}};
          end
        end
      end
    end
  endgenerate

  assign blue_serial_channel = chars[`TPE_CHAR_W-1:0];
  assign green_serial_channel = chars[2*`TPE_CHAR_W-1:`TPE_CHAR_W];
  assign red_serial_channel = chars[3*`TPE_CHAR_W-1:2*`TPE_CHAR_W];
endmodule
`default_nettype wire

// >>> bench/tpe_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpe_map.vh"
module tpe_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic input_pixel_clock,
  input wire logic host_cfg_load,
  input wire logic receiver_sense,
  input wire logic hot_plug,
  input wire logic i2c_enable,
  input wire logic char_ready,
  input wire logic char_valid,
  input wire logic [`TPE_CHAR_W-1:0] red_serial_channel,
  input wire logic [`TPE_CHAR_W-1:0] green_serial_channel,
  input wire logic [`TPE_CHAR_W-1:0] blue_serial_channel,
  input wire logic link_clock_output,
  input wire logic display_present,
  input wire logic bus_width_select,
  input wire logic edge_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [2:0] age;
  wire det = receiver_sense | (i2c_enable & hot_plug);
  // Cycles since reset release, saturating
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  sequence stalled;
    char_valid && !char_ready;
  endsequence
  sequence pclk_up;
    $rose(input_pixel_clock);
  endsequence
  sequence pclk_down;
    $fell(input_pixel_clock);
  endsequence
  hold_char_a: assert property (stalled |=> char_valid &&
    $stable({red_serial_channel, green_serial_channel, blue_serial_channel}))
    else $error("characters changed while stalled");
  link_rise_a: assert property (pclk_up |-> ##[1:6] $rose(link_clock_output))
    else $error("link clock did not follow rise");
  link_fall_a: assert property (pclk_down |-> ##[1:6] $fell(link_clock_output))
    else $error("link clock did not follow fall");
  det_on_a: assert property (det [*5] |-> display_present)
    else $error("display not reported");
  det_off_a: assert property ((!det) [*5] |-> !display_present)
    else $error("display reported without cause");
  red_ctl_a: assert property (char_valid |-> red_serial_channel != 10'h154 &&
    red_serial_channel != 10'h2AB) else $error("bad control char on red");
  green_ctl_a: assert property (char_valid |-> green_serial_channel != 10'h0AB &&
    green_serial_channel != 10'h2AB) else $error("bad control char on green");
  cfg_keep_a: assert property (age == 3'h7 && !$stable({bus_width_select, edge_select})
    |-> $past(host_cfg_load) || $past(host_cfg_load, 2)) else $error("config changed alone");
endmodule
bind tpe_encoder tpe_checker i_tpe_checker (.clk(clk), .rst_b(rst_b),
  .input_pixel_clock(input_pixel_clock), .host_cfg_load(host_cfg_load),
  .receiver_sense(receiver_sense), .hot_plug(hot_plug), .i2c_enable(i2c_enable),
  .char_ready(char_ready), .char_valid(char_valid), .red_serial_channel(red_serial_channel),
  .green_serial_channel(green_serial_channel), .blue_serial_channel(blue_serial_channel),
  .link_clock_output(link_clock_output), .display_present(display_present),
  .bus_width_select(bus_width_select), .edge_select(edge_select));
`default_nettype wire

// >>> bench/tpe_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module tpe_far_end (
  input wire logic clk,
  input wire logic run,
  input wire logic [1:0] stall_mode,
  output logic pclk,
  output logic char_ready
);
  // Pixel clock, 160 ns; a full low half opens each run, parks low when stopped
  int ph = 0;
  initial begin
    pclk = 1'b0;
    #3.3;
    forever begin
      #10;
      if (run || ph != 0) ph = (ph + 1) % 16;
      pclk = (ph >= 8);
    end
  end
  // Receiver: ready, random stalls, or full stall
  initial char_ready = 1'b1;
  always @(posedge clk) begin
    #1;
    char_ready = (stall_mode == 2'h0) || (stall_mode == 2'h1 && $urandom_range(0, 2) != 0);
  end
endmodule
`default_nettype wire

// >>> bench/test_tmds_pixel_encoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_tmds_pixel_encoder;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [23:0] pixel_data = 24'h0;
  logic data_enable = 1'b0, hsync = 1'b0, vsync = 1'b0, ctl1 = 1'b0, ctl2 = 1'b0;
  logic host_cfg_load = 1'b0, h_bus = 1'b0, h_edge = 1'b0, h_style = 1'b0;
  logic receiver_sense = 1'b0, hot_plug = 1'b0, i2c_enable = 1'b0;
  logic run = 1'b0, skip = 1'b0, bw = 1'b1, ed = 1'b1;
  logic s_bus = 1'b1, s_edge = 1'b1, s_style = 1'b0;
  logic [1:0] stall_mode = 2'h1;
  logic pclk, char_ready, pixel_ready, pixel_dropped, char_valid, present;
  logic c_bus, c_edge, c_style;
  logic [9:0] red, green, blue;
  logic [9:0] cchar[4] = '{10'h354, 10'h0AB, 10'h154, 10'h2AB};
  logic [29:0] expq[$];
  int tally[3] = '{0, 0, 0};
  int n_mismatch = 0, compares = 0;
  always #5 clk = ~clk;
  tpe_far_end i_tpe_far_end (.clk(clk), .run(run), .stall_mode(stall_mode), .pclk(pclk),
    .char_ready(char_ready));
  tpe_encoder i_tpe_encoder (.clk(clk), .rst_b(rst_b), .input_pixel_clock(pclk),
    .pixel_data(pixel_data), .data_enable(data_enable), .hsync(hsync), .vsync(vsync),
    .ctl1(ctl1), .ctl2(ctl2), .strap_bus_width_select(s_bus), .strap_edge_select(s_edge),
    .strap_clock_style_select(s_style), .host_cfg_load(host_cfg_load),
    .host_bus_width_select(h_bus), .host_edge_select(h_edge),
    .host_clock_style_select(h_style), .receiver_sense(receiver_sense), .hot_plug(hot_plug),
    .i2c_enable(i2c_enable), .char_ready(char_ready), .pixel_ready(pixel_ready),
    .pixel_dropped(pixel_dropped), .char_valid(char_valid), .red_serial_channel(red),
    .green_serial_channel(green), .blue_serial_channel(blue), .link_clock_output(),
    .display_present(present), .bus_width_select(c_bus), .edge_select(c_edge),
    .clock_style_select(c_style));
  task automatic check(input logic [29:0] seen, input logic [29:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("Counts: %0d mismatches in %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [9:0] enc(input int ch, input logic [7:0] d);
    logic [8:0] m;
    logic x;
    int c;
    x = ($countones(d) > 4) || ($countones(d) == 4 && !d[0]);
    m[0] = d[0];
    for (int i = 1; i < 8; i++) m[i] = x ^ m[i-1] ^ d[i];
    m[8] = !x;
    c = 2 * $countones(m[7:0]) - 8;
    if (tally[ch] == 0 || c == 0) begin
      enc = {~m[8], m[8], m[8] ? m[7:0] : ~m[7:0]};
      tally[ch] += m[8] ? c : -c;
    end else if ((tally[ch] > 0) == (c > 0)) begin
      enc = {1'b1, m[8], ~m[7:0]};
      tally[ch] += 2 * int'(m[8]) - c;
    end else begin
      enc = {1'b0, m[8], m[7:0]};
      tally[ch] += c - 2 * int'(!m[8]);
    end
  endfunction
  task automatic wait_for(input logic l, input logic onv);
    int k;
    k = 0;
    while ((onv ? char_valid : pclk) !== l && k < 100) begin
      @(posedge clk);
      k++;
    end
    if (k == 100) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic put(input logic l, input logic [23:0] p, input logic [4:0] c);
    wait_for(l, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    {pixel_data, data_enable, hsync, vsync, ctl1, ctl2} = {p, c};
    wait_for(~l, 1'b0);
  endtask
  task automatic pixel(input logic [23:0] p, input logic [4:0] c);
    if (c[4]) expq.push_back({enc(2, p[23:16]), enc(1, p[15:8]), enc(0, p[7:0])});
    else begin
      tally = '{0, 0, 0};
      expq.push_back({cchar[{1'b0, c[0]}], cchar[{c[1], 1'b0}], cchar[{c[2], c[3]}]});
    end
    if (bw) put(~ed, p, c);
    else begin
      put(~ed, {~p[23:12], p[11:0]}, c);
      put(ed, {~p[11:0], p[23:12]}, c);
    end
  endtask
  task automatic rnd(input int n);
    logic [4:0] c;
    c = {data_enable, hsync, vsync, ctl1, ctl2};
    repeat (n) begin
      c[4] = ($urandom_range(0, 3) != 0);
      if (!c[4]) c[3:0] = 4'($urandom);
      pixel(24'($urandom), c);
    end
  endtask
  task automatic halt();
    run = 1'b0;
    wait_for(1'b0, 1'b0);
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic cfg(input logic b, input logic e);
    {h_bus, h_edge, h_style, host_cfg_load} = {b, e, ~h_style, 1'b1};
    @(posedge clk);
    #1;
    host_cfg_load = 1'b0;
    repeat (3) @(posedge clk);
    check({c_bus, c_edge, c_style}, {b, e, h_style});
    {bw, ed, run} = {b, e, 1'b1};
  endtask
  always @(posedge clk) begin
    if (rst_b && char_valid === 1'b1 && char_ready && !skip) begin
      if (expq.size() == 0) check(30'h1, 30'h0);
      else check({red, green, blue}, expq.pop_front());
    end
  end
  initial begin
    void'($urandom(42210));
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (8) @(posedge clk);
    check({c_bus, c_edge, c_style}, 3'h6);
    for (int i = 0; i < 8; i++) begin
      #1 {receiver_sense, hot_plug, i2c_enable} = 3'(i);
      repeat (6) @(posedge clk);
      check(present, i[2] | (i[1] & i[0]));
    end
    run = 1'b1;
    for (int i = 0; i < 16; i++) pixel(24'h0, {1'b0, 4'(i)});
    foreach (cchar[i]) pixel({3{8'h0F << (2 * i)}} ^ 24'hFF00FF, 5'h10);
    rnd(40);
    halt();
    cfg(1'b1, 1'b0);
    rnd(12);
    halt();
    cfg(1'b0, 1'b1);
    rnd(12);
    halt();
    wait_for(1'b0, 1'b1);
    {skip, stall_mode, run} = {1'b1, 2'h2, 1'b1};
    rnd(6);
    halt();
    check({pixel_dropped, pixel_ready}, 2'h2);
    stall_mode = 2'h1;
    {s_bus, s_edge, s_style} = 3'h1;
    wait_for(1'b0, 1'b1);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge clk);
    check({pixel_dropped, char_valid, c_bus, c_edge, c_style}, 5'h06);
    #1 rst_b = 1'b1;
    repeat (8) @(posedge clk);
    check({c_bus, c_edge, c_style, pixel_ready}, 4'h3);
    {skip, bw, ed, run} = 4'h1;
    tally = '{0, 0, 0};
    expq.delete();
    pixel(24'h12F0C3, 5'h10);
    rnd(8);
    halt();
    wait_for(1'b0, 1'b1);
    check(30'(expq.size()), 30'h0);
    finish_test();
  end
endmodule
`default_nettype wire
